/* hw/stfs_pkg.sv */
/*
  Shared constants and state types for the supply and thermal fault status
  block: register offsets, reset values, flag positions and timing figures.
  Assumes a single 200 MHz clock.
*/
package stfs_pkg;

  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Register offsets in the seven-bit register space.
  localparam logic [6:0] ADDR_HIGH_THR = 7'h1A;
  localparam logic [6:0] ADDR_LOW_THR  = 7'h1B;
  localparam logic [6:0] ADDR_TEMP     = 7'h46;
  localparam logic [6:0] ADDR_STATUS   = 7'h5F;

  // Values after reset.
  localparam logic [7:0] HIGH_THR_RST  = 8'hFF;
  localparam logic [7:0] LOW_THR_RST   = 8'h00;
  localparam logic [7:0] TEMP_RST      = 8'h00;

  // Temperature codes: bottom of the linear range and the saturation code.
  localparam logic [7:0] TEMP_CODE_MIN = 8'h18;
  localparam logic [7:0] TEMP_CODE_MAX = 8'h82;

  // Bit positions in the fault and health status register.
  localparam int unsigned BIT_OUT1_OK   = 7;
  localparam int unsigned BIT_OUT2_OK   = 6;
  localparam int unsigned BIT_GATE_OK   = 5;
  localparam int unsigned BIT_OVERTEMP  = 4;
  localparam int unsigned BIT_LOW       = 3;
  localparam int unsigned BIT_HIGH      = 2;
  localparam int unsigned BIT_CMD_ERR   = 1;
  localparam int unsigned BIT_GATE_ERR  = 0;

  // Output filter time and gate supply start-up error time.
  localparam int unsigned FILTER_NS     = 10000;
  localparam int unsigned STARTUP_NS    = 100000;
  localparam int unsigned FILTER_CYC    =
    (FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STARTUP_CYC   =
    (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FILT_W        = 12;
  localparam int unsigned SU_W          = 20;

  typedef struct packed {
    logic              flag;
    logic [FILT_W-1:0] cnt;
  } stfs_filt_t;

  typedef struct packed {
    logic [7:0]      high_thr;
    logic [7:0]      low_thr;
    logic [7:0]      temp;
    logic [7:0]      rdata;
    logic            rvalid;
    logic [7:0]      status;
    logic            gate_avail;
    logic            overtemp;
    logic            low;
    logic            high;
    logic            cmd_err;
    logic            gate_err;
    logic            fail_silent;
    logic            gate_drive;
    logic            meas_on;
    logic            su_done;
    logic [SU_W-1:0] su_cnt;
  } stfs_state_t;

endpackage

/* hw/stfs_reg_filter.sv */
/*
  Debounce filter for one output-regulated flag. The flag follows the
  in-window input only after the input has held the opposite level for
  longer than the filter time. Assumes the input is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module stfs_reg_filter
  import stfs_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic clear_i,
  input  wire logic in_window_i,
  output logic      flag_o
);

  stfs_filt_t q;
  stfs_filt_t d;

  always_comb begin
    d = q;
    if (clear_i) begin
      d.flag = 1'b0;
      d.cnt  = '0;
    end else if (in_window_i == q.flag) begin
      d.cnt = '0;
    end else if (q.cnt == FILT_W'(FILTER_CYC)) begin
      // Set and clear alike need a run longer than the filter time.
      d.flag = in_window_i;
      d.cnt  = '0;
    end else begin
      d.cnt = q.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flag_o = q.flag;

  a_filter_set_hold: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    $rose(q.flag) |-> $past(in_window_i) && !$past(clear_i))
    else $error("Regulated flag rose without a window input.");

  a_filter_clr_hold: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    $fell(q.flag) |-> !$past(in_window_i) || $past(clear_i))
    else $error("Regulated flag fell while the output was in window.");

endmodule // stfs_reg_filter

`default_nettype wire

/* hw/stfs_status.sv */
/*
  Supply and thermal fault status block of a two-phase boost controller.
  Holds the supply thresholds, the junction temperature readout and the
  fault and health status register, and latches fail-silent mode.
  Register accesses arrive already framed and decoded, one per strobe,
  from the serial interface; that interface reports framing faults and
  its own disallowed commands on cmd_fault_i. Off mode is a synchronous
  clear; resetn_i is the power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none

module stfs_status
  import stfs_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       off_mode_i,
  input  wire logic       reg_valid_i,
  input  wire logic       reg_write_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       cmd_fault_i,
  input  wire logic [7:0] supply_code_i,
  input  wire logic [7:0] temp_code_i,
  input  wire logic       out1_en_i,
  input  wire logic       out2_en_i,
  input  wire logic       out1_in_window_i,
  input  wire logic       out2_in_window_i,
  input  wire logic       gate_reg_en_i,
  input  wire logic       gate_in_window_i,
  input  wire logic       gate_in_range_i,
  input  wire logic       gate_overload_i,
  output logic [7:0]      reg_rdata_o,
  output logic            reg_rvalid_o,
  output logic [7:0]      status_o,
  output logic [7:0]      supply_high_threshold_o,
  output logic [7:0]      supply_low_threshold_o,
  output logic            fail_silent_o,
  output logic            gate_drive_en_o,
  output logic            meas_active_o
);

  // Sticky flag update in which a set in the clearing cycle wins.
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = (cur & ~clr) | set;
  endfunction

  // Saturate the raw temperature code at the top of the reported range.
  function automatic logic [7:0] temp_clamp(input logic [7:0] code);
    temp_clamp = (code > TEMP_CODE_MAX) ? TEMP_CODE_MAX : code;
  endfunction

  stfs_state_t q;
  stfs_state_t d;
  logic        out1_ok;
  logic        out2_ok;

  stfs_reg_filter u_out1_filter (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .clear_i     (off_mode_i),
    .in_window_i (out1_in_window_i),
    .flag_o      (out1_ok)
  );

  stfs_reg_filter u_out2_filter (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .clear_i     (off_mode_i),
    .in_window_i (out2_in_window_i),
    .flag_o      (out2_ok)
  );

  logic       wr_stat;
  logic       wr_bad;
  logic       set_high;
  logic       set_low;
  logic       set_temp;
  logic       set_cmd;
  logic       su_timeout;
  logic       gate_lost;
  logic       set_gerr;
  logic [7:0] status_now;

  always_comb begin
    d = q;
    // Status writes only clear the sticky flags; a faulty one is refused.
    wr_stat = reg_valid_i & reg_write_i & ~cmd_fault_i &
              (reg_addr_i == ADDR_STATUS);
    wr_bad  = reg_valid_i & reg_write_i & (reg_addr_i == ADDR_TEMP);
    set_cmd = wr_bad | cmd_fault_i;

    d.meas_on = (out1_en_i | out2_en_i) & q.gate_avail;
    set_high  = q.meas_on & (supply_code_i > q.high_thr);
    set_low   = q.meas_on & (supply_code_i < q.low_thr);
    set_temp  = (temp_code_i >= TEMP_CODE_MAX);
    d.temp    = temp_clamp(temp_code_i);

    // Gate supply start-up supervision.
    su_timeout = gate_reg_en_i & ~q.su_done & ~gate_in_window_i &
                 (q.su_cnt == SU_W'(STARTUP_CYCLES));
    gate_lost  = q.su_done & q.gate_avail & ~gate_in_window_i &
                 gate_in_range_i;
    set_gerr   = su_timeout | gate_overload_i;
    if (!gate_reg_en_i) begin
      d.su_cnt = '0;
    end else if (!q.su_done) begin
      if (gate_in_window_i) begin
        d.su_done    = 1'b1;
        d.gate_avail = 1'b1;
      end else if (su_timeout) begin
        d.su_done = 1'b1;
      end else begin
        d.su_cnt = q.su_cnt + SU_W'(1);
      end
    end
    if (gate_lost | gate_overload_i | ~gate_reg_en_i) begin
      d.gate_avail = 1'b0;
    end

    d.high     = sticky(q.high, set_high, wr_stat);
    d.low      = sticky(q.low, set_low, wr_stat);
    d.overtemp = sticky(q.overtemp, set_temp, wr_stat);
    d.cmd_err  = sticky(q.cmd_err, set_cmd, wr_stat);
    d.gate_err = sticky(q.gate_err, set_gerr, wr_stat);

    // Fail-silent ignores status writes; only Off mode leaves it.
    d.fail_silent = q.fail_silent | set_high | set_low | set_temp |
                    set_gerr | gate_lost;
    d.gate_drive  = d.gate_avail & ~d.fail_silent;

    // Threshold writes are ignored when the access carries a fault.
    if (reg_valid_i & reg_write_i & ~cmd_fault_i) begin
      if (reg_addr_i == ADDR_HIGH_THR) begin
        d.high_thr = reg_wdata_i;
      end
      if (reg_addr_i == ADDR_LOW_THR) begin
        d.low_thr = reg_wdata_i;
      end
    end

    status_now = '0;
    status_now[BIT_OUT1_OK]  = out1_ok;
    status_now[BIT_OUT2_OK]  = out2_ok;
    status_now[BIT_GATE_OK]  = q.gate_avail;
    status_now[BIT_OVERTEMP] = q.overtemp;
    status_now[BIT_LOW]      = q.low;
    status_now[BIT_HIGH]     = q.high;
    status_now[BIT_CMD_ERR]  = q.cmd_err;
    status_now[BIT_GATE_ERR] = q.gate_err;
    d.status = status_now;

    // Answer: valid read returns content, valid threshold write the new content, status write the content before its clear.
    d.rvalid = reg_valid_i;
    d.rdata  = '0;
    if (reg_valid_i & ~set_cmd) begin
      case (reg_addr_i)
        ADDR_HIGH_THR: d.rdata = d.high_thr;
        ADDR_LOW_THR:  d.rdata = d.low_thr;
        ADDR_TEMP:     d.rdata = q.temp;
        ADDR_STATUS:   d.rdata = status_now;
        default:       d.rdata = '0;
      endcase
    end

    if (off_mode_i) begin
      d            = '0;
      d.high_thr   = HIGH_THR_RST;
      d.low_thr    = LOW_THR_RST;
      d.temp       = TEMP_RST;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q          <= '0;
      q.high_thr <= HIGH_THR_RST;
      q.low_thr  <= LOW_THR_RST;
      q.temp     <= TEMP_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o             = q.rdata;
  assign reg_rvalid_o            = q.rvalid;
  assign status_o                = q.status;
  assign supply_high_threshold_o = q.high_thr;
  assign supply_low_threshold_o  = q.low_thr;
  assign fail_silent_o           = q.fail_silent;
  assign gate_drive_en_o         = q.gate_drive;
  assign meas_active_o           = q.meas_on;

  a_high_sets_flag: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    q.meas_on && supply_code_i > q.high_thr && !off_mode_i
    |=> q.high && q.fail_silent)
    else $error("Supply above threshold did not set high flag.");

  a_low_sets_flag: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    q.meas_on && supply_code_i < q.low_thr && !off_mode_i
    |=> q.low && q.fail_silent)
    else $error("Supply below threshold did not set low flag.");

  a_meas_gated: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    q.meas_on |-> $past(q.gate_avail) &&
                  ($past(out1_en_i) || $past(out2_en_i)))
    else $error("Supply compare ran without enable and gate supply.");

  a_fail_latched: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    q.fail_silent && !off_mode_i |=> q.fail_silent)
    else $error("Fail-silent left without Off mode.");

  a_write_clears: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    reg_valid_i && reg_write_i && reg_addr_i == ADDR_STATUS &&
    !q.meas_on && !cmd_fault_i && temp_code_i < TEMP_CODE_MAX &&
    !gate_overload_i && !su_timeout
    |=> !q.high && !q.low && !q.cmd_err && !q.overtemp && !q.gate_err)
    else $error("Status write did not clear sticky flags.");

  a_ro_write_err: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    reg_valid_i && reg_write_i && reg_addr_i == ADDR_TEMP && !off_mode_i
    |=> q.cmd_err && q.rvalid && q.rdata == 8'h00)
    else $error("Read-only write did not raise command error.");

  a_overtemp_fs: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    temp_code_i >= TEMP_CODE_MAX && !off_mode_i
    |=> q.overtemp && q.fail_silent && q.temp == TEMP_CODE_MAX)
    else $error("Overtemperature did not set flag and fail-silent.");

  a_gate_drive_ok: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    q.gate_drive |-> q.gate_avail && !q.fail_silent)
    else $error("Gate outputs driven without gate supply available.");

  a_startup_fault: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    su_timeout && !off_mode_i |=> q.gate_err && q.fail_silent)
    else $error("Gate supply start-up timeout not flagged.");

  a_gate_lost: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    gate_lost && !off_mode_i |=> !q.gate_avail && q.fail_silent)
    else $error("Gate supply loss not handled.");

  a_status_map: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    !$past(off_mode_i) |-> q.status[BIT_HIGH] == $past(q.high) &&
      q.status[BIT_GATE_OK] == $past(q.gate_avail))
    else $error("Status register bit map mismatch.");

  a_off_clears: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    off_mode_i |=> !q.high && !q.low && !q.cmd_err && !q.overtemp &&
                   !q.gate_err && !q.fail_silent)
    else $error("Off mode did not clear flags and fail-silent.");

  a_fault_flags: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    reg_valid_i && cmd_fault_i && !off_mode_i
    |=> q.cmd_err && q.rvalid && q.rdata == 8'h00)
    else $error("Faulty access did not raise command error.");

  a_fault_no_apply: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    reg_valid_i && reg_write_i && cmd_fault_i && !off_mode_i
    |=> $stable(q.high_thr) && $stable(q.low_thr))
    else $error("Faulty write changed a threshold.");

  a_thr_write: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    reg_valid_i && reg_write_i && !cmd_fault_i && !off_mode_i &&
    reg_addr_i == ADDR_HIGH_THR
    |=> q.high_thr == $past(reg_wdata_i) && q.rdata == $past(reg_wdata_i))
    else $error("High threshold write did not land or echo.");

  a_temp_readout: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    temp_code_i < TEMP_CODE_MAX && !off_mode_i
    |=> q.temp == $past(temp_code_i))
    else $error("Temperature readout does not follow the code.");

  a_status_flags: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    !$past(off_mode_i) |-> q.status[BIT_OVERTEMP] == $past(q.overtemp) &&
      q.status[BIT_LOW] == $past(q.low) &&
      q.status[BIT_CMD_ERR] == $past(q.cmd_err) &&
      q.status[BIT_GATE_ERR] == $past(q.gate_err))
    else $error("Status register fault bits mismatch.");

  a_regulated_map: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    !$past(off_mode_i) |-> q.status[BIT_OUT1_OK] == $past(out1_ok) &&
      q.status[BIT_OUT2_OK] == $past(out2_ok))
    else $error("Status register regulated bits mismatch.");

  a_overload_gerr: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    gate_overload_i && !off_mode_i
    |=> q.gate_err && !q.gate_avail && q.fail_silent)
    else $error("Gate supply overload not handled.");

  a_gate_avail_window: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    $rose(q.gate_avail) |-> $past(gate_in_window_i) && $past(gate_reg_en_i))
    else $error("Gate supply reported available outside its window.");

  c_high_fault: cover property (@(posedge ref_clk_i)
    disable iff (!resetn_i) $rose(q.high));
  c_clear_write: cover property (@(posedge ref_clk_i)
    disable iff (!resetn_i) q.high ##1 !q.high && q.fail_silent);
  c_gate_up: cover property (@(posedge ref_clk_i)
    disable iff (!resetn_i) $rose(q.gate_drive));
  c_out1_ok: cover property (@(posedge ref_clk_i)
    disable iff (!resetn_i) $rose(out1_ok));
  c_gate_fault: cover property (@(posedge ref_clk_i)
    disable iff (!resetn_i) $rose(q.gate_err));

endmodule // stfs_status

`default_nettype wire

/* verif/stfs_mcu_model.sv */
/*
  Model of the controlling microcontroller on the far side of the status
  block. It issues one decoded register access per call.
  Assumes the bench calls its task from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module stfs_mcu_model (
  input  wire logic  ref_clk_i,
  output logic       reg_valid_o,
  output logic       reg_write_o,
  output logic [6:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic       cmd_fault_o
);
  initial begin
    reg_valid_o = 1'b0;
    reg_write_o = 1'b0;
    reg_addr_o  = 7'h00;
    reg_wdata_o = 8'h00;
    cmd_fault_o = 1'b0;
  end

  // Released write, address and data lines show the inverse of the last value so stale data
  // can never pass for a fresh request.
  task automatic access(input logic wr, input logic [6:0] addr,
                        input logic [7:0] data, input logic flt);
    @(negedge ref_clk_i);
    reg_valid_o = 1'b1;
    reg_write_o = wr;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    cmd_fault_o = flt;
    @(negedge ref_clk_i);
    reg_valid_o = 1'b0;
    cmd_fault_o = 1'b0;
    reg_write_o = ~wr;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask
endmodule // stfs_mcu_model

`default_nettype wire

/* verif/tb_top.sv */
/*
  Self-checking bench for the supply and thermal fault status block.
  Assumes the design package and the microcontroller model are compiled
  first; read answers are checked against a queue of expected bytes.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import stfs_pkg::*;
;

  localparam int unsigned SU = 20;

  logic ref_clk_i = 1'b0;
  logic resetn_i, off_mode_i, reg_valid_i, reg_write_i, cmd_fault_i;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, supply_code_i, temp_code_i, thr;
  logic out1_en_i, out2_en_i, out1_in_window_i, out2_in_window_i;
  logic gate_reg_en_i, gate_in_window_i, gate_in_range_i, gate_overload_i;
  logic [7:0] reg_rdata_o, status_o, hi_o, lo_o;
  logic reg_rvalid_o, fail_silent_o, gate_drive_en_o, meas_active_o;
  logic [15:0] exp_e;
  logic [15:0] exp_q[$];
  int seed = 24;
  int miscompares = 0;
  int checked = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  stfs_mcu_model mcu_u (.ref_clk_i(ref_clk_i), .reg_valid_o(reg_valid_i),
    .reg_write_o(reg_write_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .cmd_fault_o(cmd_fault_i));

  stfs_status #(.STARTUP_CYCLES(SU)) dut_u (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .off_mode_i(off_mode_i),
    .reg_valid_i(reg_valid_i), .reg_write_i(reg_write_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .cmd_fault_i(cmd_fault_i), .supply_code_i(supply_code_i),
    .temp_code_i(temp_code_i), .out1_en_i(out1_en_i),
    .out2_en_i(out2_en_i), .out1_in_window_i(out1_in_window_i),
    .out2_in_window_i(out2_in_window_i), .gate_reg_en_i(gate_reg_en_i),
    .gate_in_window_i(gate_in_window_i), .gate_in_range_i(gate_in_range_i),
    .gate_overload_i(gate_overload_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .status_o(status_o),
    .supply_high_threshold_o(hi_o), .supply_low_threshold_o(lo_o),
    .fail_silent_o(fail_silent_o), .gate_drive_en_o(gate_drive_en_o),
    .meas_active_o(meas_active_o));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Notes the masked expectation, then issues the access.
  task automatic rw(input logic wr, input logic [6:0] a, input logic [7:0] d,
                    input logic [7:0] m, input logic [7:0] e,
                    input logic f = 1'b0);
    exp_q.push_back({m, e & m});
    mcu_u.access(wr, a, d, f);
  endtask

  task automatic off_pulse();
    off_mode_i = 1'b1;
    cyc(1);
    off_mode_i = 1'b0;
    cyc(2);
  endtask

  task automatic give_verdict();
    if (exp_q.size() != 0) miscompares++;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(negedge ref_clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      exp_e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hFFFF;
      cmp(reg_rdata_o & exp_e[15:8], exp_e[7:0]);
    end
  end

  initial begin
    cyc(40000);
    miscompares++;
    give_verdict();
  end

  initial begin
    {resetn_i, off_mode_i, out1_en_i, out2_en_i} = 4'h0;
    {out1_in_window_i, out2_in_window_i, gate_reg_en_i} = 3'h0;
    {gate_in_window_i, gate_in_range_i, gate_overload_i} = 3'h0;
    supply_code_i = 8'h80;
    temp_code_i = 8'h30;
    cyc(2);
    resetn_i = 1'b1;
    cyc(1);
    rw(1'b1, ADDR_STATUS, 8'h00, 8'h00, 8'h00);
    rw(1'b0, ADDR_HIGH_THR, 8'h00, 8'hFF, HIGH_THR_RST);
    rw(1'b0, ADDR_LOW_THR, 8'h00, 8'hFF, LOW_THR_RST);
    rw(1'b0, ADDR_STATUS, 8'h00, 8'hFF, 8'h00);
    rw(1'b1, ADDR_TEMP, 8'h55, 8'hFF, 8'h00);
    rw(1'b0, 7'h30, 8'h00, 8'hFF, 8'h00);
    rw(1'b0, ADDR_STATUS, 8'h00, 8'hFF, 8'h02);
    thr = {1'b0, 7'($random(seed))} + 8'h10;
    rw(1'b1, ADDR_HIGH_THR, thr, 8'hFF, thr);
    rw(1'b1, ADDR_HIGH_THR, ~thr, 8'hFF, 8'h00, 1'b1);
    rw(1'b0, ADDR_HIGH_THR, 8'h00, 8'hFF, thr);
    // Supply compare: equal is quiet, one code above trips.
    {gate_reg_en_i, gate_in_window_i, gate_in_range_i, out1_en_i} = 4'hF;
    supply_code_i = thr;
    cyc(5);
    cmp({7'h0, meas_active_o}, 8'h01);
    cmp({7'h0, gate_drive_en_o}, 8'h01);
    cmp({7'h0, fail_silent_o}, 8'h00);
    supply_code_i = thr + 8'h01;
    cyc(3);
    cmp({7'h0, fail_silent_o}, 8'h01);
    cmp({7'h0, gate_drive_en_o}, 8'h00);
    supply_code_i = thr;
    rw(1'b0, ADDR_STATUS, 8'h00, 8'h1F, 8'h06);
    rw(1'b1, ADDR_STATUS, 8'h00, 8'h00, 8'h00);
    rw(1'b0, ADDR_STATUS, 8'h00, 8'h1F, 8'h00);
    cmp({7'h0, fail_silent_o}, 8'h01);
    off_pulse();
    cmp(hi_o, HIGH_THR_RST);
    cmp({7'h0, fail_silent_o}, 8'h00);
    rw(1'b1, ADDR_LOW_THR, 8'h40, 8'hFF, 8'h40);
    supply_code_i = 8'h3F;
    cyc(4);
    cmp({7'h0, fail_silent_o}, 8'h01);
    supply_code_i = 8'h40;
    rw(1'b0, ADDR_STATUS, 8'h00, 8'h1F, 8'h08);
    rw(1'b1, ADDR_STATUS, 8'h00, 8'h00, 8'h00);
    rw(1'b0, ADDR_STATUS, 8'h00, 8'h1F, 8'h00);
    cmp({7'h0, fail_silent_o}, 8'h01);
    off_pulse();
    cmp(lo_o, LOW_THR_RST);
    temp_code_i = 8'h95;
    cyc(3);
    cmp({7'h0, fail_silent_o}, 8'h01);
    rw(1'b0, ADDR_TEMP, 8'h00, 8'hFF, TEMP_CODE_MAX);
    rw(1'b0, ADDR_STATUS, 8'h00, 8'h1F, 8'h10);
    temp_code_i = TEMP_CODE_MIN;
    rw(1'b1, ADDR_STATUS, 8'h00, 8'h00, 8'h00);
    rw(1'b0, ADDR_STATUS, 8'h00, 8'h1F, 8'h00);
    cmp({7'h0, fail_silent_o}, 8'h01);
    off_pulse();
    rw(1'b0, ADDR_TEMP, 8'h00, 8'hFF, TEMP_CODE_MIN);
    temp_code_i = 8'h81;
    cyc(3);
    rw(1'b0, ADDR_TEMP, 8'h00, 8'hFF, 8'h81);
    cyc(2);
    cmp({7'h0, status_o[BIT_GATE_OK]}, 8'h01);
    gate_in_window_i = 1'b0;
    cyc(3);
    cmp({7'h0, status_o[BIT_GATE_OK]}, 8'h00);
    cmp({7'h0, fail_silent_o}, 8'h01);
    off_pulse();
    cyc(SU + 5);
    cmp({7'h0, fail_silent_o}, 8'h01);
    rw(1'b0, ADDR_STATUS, 8'h00, 8'h21, 8'h01);
    gate_in_window_i = 1'b1;
    off_pulse();
    gate_overload_i = 1'b1;
    cyc(1);
    gate_overload_i = 1'b0;
    cyc(3);
    cmp({7'h0, status_o[BIT_GATE_ERR]}, 8'h01);
    off_pulse();
    {out1_in_window_i, out2_in_window_i} = 2'b11;
    cyc(FILTER_CYC - 5);
    cmp(status_o & 8'hC0, 8'h00);
    cyc(10);
    cmp(status_o & 8'hC0, 8'hC0);
    {out1_in_window_i, out2_in_window_i} = 2'b00;
    cyc(FILTER_CYC - 5);
    cmp(status_o & 8'hC0, 8'hC0);
    cyc(10);
    cmp(status_o & 8'hC0, 8'h00);
    cyc(3);
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
